//--- dprm_chk.sv
// port assertions for the message handler
module dprm_chk
   import dprm_pkg::*;
#(
   parameter int FRAME_BYTES = 128
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic rxEnd,
   input wire logic frameReady,
   input wire logic frameValid,
   input wire logic [15:0] frameChannel,
   input wire logic [7:0] framePort,
   input wire logic [31:0] frameLen,
   input wire logic frameLast,
   input wire logic outstanding,
   input wire logic ackValid,
   input wire logic alertValid
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // any answer to a finished message
   sequence s_reply;
      ackValid || alertValid || $rose(outstanding);
   endsequence
   a_reply_after_end: assert property (rxEnd |-> ##[1:5] s_reply)
      else $error("no answer after message end");
   a_ack_pulse: assert property (ackValid |=> !ackValid)
      else $error("ack longer than one cycle");
   a_alert_pulse: assert property (alertValid |=> !alertValid)
      else $error("alert longer than one cycle");
   a_one_reply: assert property (!(ackValid && alertValid))
      else $error("ack and alert together");
   a_frame_held: assert property (frameValid && !frameReady |=>
      frameValid && $stable(frameLen))
      else $error("frame dropped before accept");
   a_frame_size: assert property (frameValid |->
      frameLen != 0 && frameLen <= FRAME_BYTES)
      else $error("frame length out of range");
   a_frame_owned: assert property (frameValid |-> outstanding)
      else $error("frame without outstanding transfer");
   a_last_ends: assert property (frameValid && frameReady && frameLast
      |=> !outstanding)
      else $error("outstanding after last frame");
   a_addr_steady: assert property (outstanding && $past(outstanding) |->
      $stable(frameChannel) && $stable(framePort))
      else $error("frame address moved mid transfer");
endmodule

//--- dprm_frame_sender.sv
// data frame sender: splits one granted transfer into frames
module dprm_frame_sender
   import dprm_pkg::*;
#(
   parameter int FRAME_BYTES = 128
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic start,
   input wire logic [31:0] count,
   input wire logic frameReady,
   output logic busy,
   output logic frameValid,
   output logic [31:0] frameLen,
   output logic lastFrame
);
   localparam logic [31:0] FB = 32'(FRAME_BYTES);
   logic [31:0] left_q;
   logic [31:0] chunk;

   // each frame holds data of exactly one transfer
   always_comb begin
      chunk = (left_q > FB) ? FB : left_q;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         left_q <= RST_WORD;
         busy <= 1'b0;
         frameValid <= 1'b0;
         frameLen <= RST_WORD;
         lastFrame <= 1'b0;
      end else if (start && !busy) begin
         left_q <= count;
         busy <= (count != RST_WORD);
         frameValid <= 1'b0;
         lastFrame <= 1'b0;
      end else if (busy && (!frameValid || frameReady)) begin
         frameValid <= 1'b1;
         frameLen <= chunk;
         lastFrame <= (left_q <= FB);
         left_q <= left_q - chunk;
         busy <= (left_q > FB);
      end else if (frameValid && frameReady) begin
         frameValid <= 1'b0;
         lastFrame <= 1'b0;
      end
   end
endmodule

//--- dprm_msg_handler.sv
// receives pull requests and grants, checks them, drives data frames
// Functional notes
// - pull request is code 22h, tag, offset, count, channel at fixed bytes.
// - pull request outstanding until its last data frame is delivered.
// - offset plus count within transfer length; receiver check optional.
// - same channel transfers run in order; different channels may overlap; the code alerts any second transfer with TOO_MANY_CODE, whatever its channel.
// - on pull request send frames to requested channel via origin port.
// - one data frame never carries data of two requests.
// - grant is code 23h with tag, issuer, count, channel, offer, route, port.
// - grant data leaves on named port along named route.
// - grant outstanding until the third party gets its last frame.
// - issuer mismatch raises alert with bad issuer code, keep waiting.
// - grant count breaking modulo eight rejected with bad field code; the code accepts such a count when it equals cmdLength.
// - grant frames use channel field and route field, exit named port.
// - same channel grants finish in order; different channels may overlap; the code alerts any second grant with TOO_MANY_CODE, whatever its channel.
// - bad field gets acknowledge; bad issuer, unexpected, too many get alert.
// - rejecting a grant does not end the I/O process.
module dprm_msg_handler
   import dprm_pkg::*;
#(
   parameter int FRAME_BYTES = 128,
   parameter bit CHECK_LENGTH = 1'b1
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic rxValid,
   input wire logic [7:0] rxByte,
   input wire logic rxEnd,
   input wire logic [15:0] cmdTag,
   input wire logic [31:0] cmdIssuer,
   input wire logic [31:0] cmdLength,
   input wire logic [7:0] cmdPort,
   input wire logic [31:0] cmdRoute,
   input wire logic cmdActive,
   input wire logic frameReady,
   output logic frameValid,
   output logic [15:0] frameChannel,
   output logic [31:0] frameRoute,
   output logic [7:0] framePort,
   output logic [31:0] frameLen,
   output logic frameLast,
   output logic outstanding,
   output logic ackValid,
   output logic [7:0] ackCode,
   output logic alertValid,
   output logic [7:0] alertCode,
   output logic [15:0] replyTag
);
   logic rstMeta_q, rstN_q;
   logic [7:0] buf_q [MAX_LEN];
   logic [4:0] cnt_q;
   logic over_q;
   dprm_state_t state_q;
   logic [15:0] lastChan_q;
   logic lastValid_q;
   logic startSend;
   logic busy, sendValid, sendLast;
   logic [31:0] sendLen;
   logic stageReady;
   logic [7:0] code;
   logic [15:0] tag, chan;
   logic [31:0] wOffCnt, count, route;
   logic isPull, isGrant;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstN_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q <= rstMeta_q;
      end
   end

   // big-endian field extraction
   function automatic logic [31:0] be32(input int p);
      be32 = {buf_q[p], buf_q[p+1], buf_q[p+2], buf_q[p+3]};
   endfunction
   function automatic logic [15:0] be16(input int p);
      be16 = {buf_q[p], buf_q[p+1]};
   endfunction

   always_comb begin
      code = buf_q[POS_CODE];
      tag = be16(POS_TAG);
      wOffCnt = be32(POS_OFFSET);
      count = be32(POS_COUNT);
      chan = be16(POS_CHAN);
      route = be32(POS_ROUTE);
      isPull = (code == CODE_PULL) && (cnt_q == 5'(PULL_LEN));
      isGrant = (code == CODE_GRANT) && (cnt_q == 5'(GRANT_LEN));
   end

   // byte capture of an incoming message
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         cnt_q <= 5'h00;
         over_q <= 1'b0;
         for (int i = 0; i < MAX_LEN; i++) begin
            buf_q[i] <= 8'h00;
         end
      end else if (state_q == DPRM_EVAL) begin
         cnt_q <= 5'h00;
         over_q <= 1'b0;
      end else if (rxValid && state_q != DPRM_EVAL) begin
         if (cnt_q < 5'(MAX_LEN)) begin
            buf_q[cnt_q] <= rxByte;
            cnt_q <= cnt_q + 5'h01;
         end else begin
            over_q <= 1'b1;
         end
      end
   end

   // message sequencing
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         state_q <= DPRM_IDLE;
      end else begin
         case (state_q)
            DPRM_IDLE: begin
               if (rxValid) state_q <= DPRM_RECV;
            end
            DPRM_RECV: begin
               if (rxEnd) state_q <= DPRM_EVAL;
            end
            DPRM_EVAL: begin
               state_q <= DPRM_IDLE;
            end
            default: begin
               state_q <= DPRM_IDLE;
            end
         endcase
      end
   end

   // checks, replies and transfer start
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         ackValid <= 1'b0;
         ackCode <= 8'h00;
         alertValid <= 1'b0;
         alertCode <= 8'h00;
         replyTag <= 16'h0000;
         startSend <= 1'b0;
         frameChannel <= 16'h0000;
         frameRoute <= RST_WORD;
         framePort <= 8'h00;
         lastChan_q <= 16'h0000;
         lastValid_q <= 1'b0;
      end else begin
         ackValid <= 1'b0;
         alertValid <= 1'b0;
         startSend <= 1'b0;
         if (state_q == DPRM_EVAL) begin
            replyTag <= tag;
            if (over_q || !(isPull || isGrant) || !cmdActive
                  || tag != cmdTag) begin
               alertValid <= 1'b1;
               alertCode <= UNEXPECTED_CODE;
            end else if (busy || startSend || outstanding) begin
               alertValid <= 1'b1;
               alertCode <= TOO_MANY_CODE;
            end else if (isGrant && be32(POS_ISSUER) != cmdIssuer) begin
               alertValid <= 1'b1;
               alertCode <= BAD_ISSUER_CODE;
            end else if (isGrant && count[2:0] != 3'h0
                  && count != cmdLength) begin
               ackValid <= 1'b1;
               ackCode <= BAD_FIELD_CODE;
            end else if (isPull && CHECK_LENGTH
                  && (33'(wOffCnt) + 33'(count)) > 33'(cmdLength)) begin
               ackValid <= 1'b1;
               ackCode <= BAD_FIELD_CODE;
            end else begin
               startSend <= 1'b1;
               frameChannel <= chan;
               lastChan_q <= chan;
               lastValid_q <= 1'b1;
               if (isGrant) begin
                  frameRoute <= route;
                  framePort <= buf_q[POS_PORT];
               end else begin
                  frameRoute <= cmdRoute;
                  framePort <= cmdPort;
               end
            end
         end
      end
   end

   // one transfer at a time keeps frames from mixing requests
   dprm_frame_sender #(
      .FRAME_BYTES(FRAME_BYTES)
   ) uSender (
      .clk(clk_sys),
      .rstN(rstN_q),
      .start(startSend),
      .count(count),
      .frameReady(stageReady),
      .busy(busy),
      .frameValid(sendValid),
      .frameLen(sendLen),
      .lastFrame(sendLast)
   );

   // output stage takes a frame only when empty or being drained
   assign stageReady = !frameValid || frameReady;

   // registered frame outputs and outstanding flag
   always_ff @(posedge clk_sys or negedge rstN_q) begin
      if (!rstN_q) begin
         frameValid <= 1'b0;
         frameLen <= RST_WORD;
         frameLast <= 1'b0;
         outstanding <= 1'b0;
      end else begin
         if (stageReady) begin
            frameValid <= sendValid;
            frameLen <= sendLen;
            frameLast <= sendLast;
         end
         if (startSend) begin
            outstanding <= 1'b1;
         end else if (frameValid && frameReady && frameLast) begin
            outstanding <= 1'b0;
         end
      end
   end
endmodule

//--- dprm_peer.sv
// frame sink for the peer node, stalls every other cycle when slow
module dprm_peer (
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic clr,
   input wire logic frameValid,
   input wire logic [31:0] frameLen,
   input wire logic frameLast,
   output logic frameReady,
   output logic [31:0] gotBytes,
   output logic [7:0] gotFrames,
   output logic gotLast
);
   timeunit 1ns;
   timeprecision 1ns;
   // ready pattern off the sampling edge
   always @(negedge clk_sys) frameReady <= !(slow && frameReady);
   // tally accepted frames
   always @(posedge clk_sys) begin
      if (clr) begin
         gotBytes <= 32'h0;
         gotFrames <= 8'h0;
         gotLast <= 1'b0;
      end else if (frameValid && frameReady) begin
         gotBytes <= gotBytes + frameLen;
         gotFrames <= gotFrames + 8'h1;
         gotLast <= frameLast;
      end
   end
endmodule

//--- dprm_pkg.sv
// constants and types for the pull request and third party grant handler
package dprm_pkg;
   localparam logic [7:0] CODE_PULL = 8'h22;
   localparam logic [7:0] CODE_GRANT = 8'h23;
   localparam int PULL_LEN = 14;
   localparam int GRANT_LEN = 21;
   localparam int MAX_LEN = 21;
   // byte positions
   localparam int POS_CODE = 0;
   localparam int POS_TAG = 2;
   localparam int POS_OFFSET = 4;
   localparam int POS_ISSUER = 4;
   localparam int POS_COUNT = 8;
   localparam int POS_CHAN = 12;
   localparam int POS_OFFER = 14;
   localparam int POS_ROUTE = 16;
   localparam int POS_PORT = 20;
   // reply codes, values arbitrary
   localparam logic [7:0] BAD_FIELD_CODE = 8'h01;
   localparam logic [7:0] BAD_ISSUER_CODE = 8'h02;
   localparam logic [7:0] UNEXPECTED_CODE = 8'h03;
   localparam logic [7:0] TOO_MANY_CODE = 8'h04;
   localparam logic [31:0] RST_WORD = 32'h00000000;
   typedef enum logic [1:0] {
      DPRM_IDLE = 2'b00,
      DPRM_RECV = 2'b01,
      DPRM_EVAL = 2'b10,
      DPRM_XFER = 2'b11
   } dprm_state_t;
endpackage

//--- tb.sv
// self-checking bench for the message handler
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dprm_pkg::*;
   logic clk_sys, nrst, rxValid, rxEnd, cmdActive, frameReady, slow, clr;
   logic [7:0] rxByte, cmdPort, framePort, ackCode, alertCode, gotFrames;
   logic [15:0] cmdTag, frameChannel, replyTag;
   logic [31:0] cmdIssuer, cmdLength, cmdRoute, frameRoute, frameLen;
   logic [31:0] gotBytes;
   logic frameValid, frameLast, outstanding, ackValid, alertValid, gotLast;
   logic [7:0] ak, al;
   int error_cnt, cmp_count;
   dprm_msg_handler #(.FRAME_BYTES(8)) i_dut (.clk_sys(clk_sys),
      .nrst(nrst), .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd),
      .cmdTag(cmdTag), .cmdIssuer(cmdIssuer), .cmdLength(cmdLength),
      .cmdPort(cmdPort), .cmdRoute(cmdRoute), .cmdActive(cmdActive),
      .frameReady(frameReady), .frameValid(frameValid),
      .frameChannel(frameChannel), .frameRoute(frameRoute),
      .framePort(framePort), .frameLen(frameLen), .frameLast(frameLast),
      .outstanding(outstanding), .ackValid(ackValid), .ackCode(ackCode),
      .alertValid(alertValid), .alertCode(alertCode), .replyTag(replyTag));
   dprm_peer i_peer (.clk_sys(clk_sys), .slow(slow), .clr(clr),
      .frameValid(frameValid), .frameLen(frameLen), .frameLast(frameLast),
      .frameReady(frameReady), .gotBytes(gotBytes), .gotFrames(gotFrames),
      .gotLast(gotLast));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [167:0] pull(input logic [31:0] cnt,
      input logic [15:0] ch);
      return {CODE_PULL, 8'h00, cmdTag, 32'h0, cnt, ch, 56'h0};
   endfunction
   function automatic logic [167:0] grant(input logic [31:0] iss, cnt,
      input logic [15:0] ch);
      return {CODE_GRANT, 8'h00, cmdTag, iss, cnt, ch, 16'h0007,
         32'hA5A50F0F, 8'h03};
   endfunction
   // bytes most significant first, end flag on the last
   task automatic send(input logic [167:0] m, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         rxValid = 1'b1;
         rxByte = m[167-8*i -: 8];
         rxEnd = (i == n - 1);
      end
      @(negedge clk_sys);
      rxValid = 1'b0;
      rxEnd = 1'b0;
   endtask
   task automatic prep(input logic s);
      @(negedge clk_sys);
      slow = s;
      clr = 1'b1;
      @(negedge clk_sys);
      clr = 1'b0;
   endtask
   task automatic wait_reply;
      ak = 8'h00;
      al = 8'h00;
      repeat (8) begin
         @(negedge clk_sys);
         if (ackValid === 1'b1) ak = ackCode;
         if (alertValid === 1'b1) al = alertCode;
      end
   endtask
   task automatic wait_done;
      int n;
      n = 0;
      while (gotLast !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > 900) begin
            chk(32'h0, 32'h1);
            give_verdict();
         end
      end
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic t_pull;
      prep(1'b0);
      send(pull(32'd20, 16'h0005), PULL_LEN);
      wait_done();
      chk(gotBytes, 32'd20);
      chk(gotFrames, 32'd3);
      chk(frameChannel, 32'h5);
      chk(framePort, cmdPort);
      chk(frameRoute, cmdRoute);
      chk(outstanding, 32'h0);
   endtask
   task automatic t_busy;
      prep(1'b1);
      send(pull(32'd200, 16'h0006), PULL_LEN);
      repeat (4) @(negedge clk_sys);
      send(grant(cmdIssuer, 32'd16, 16'h0009), GRANT_LEN);
      wait_reply();
      chk(al, TOO_MANY_CODE);
      wait_done();
      chk(gotBytes, 32'd200);
   endtask
   task automatic t_bad(input logic [31:0] iss, input logic [31:0] cnt,
      input logic [7:0] eak, input logic [7:0] eal);
      prep(1'b0);
      send(grant(iss, cnt, 16'h0009), GRANT_LEN);
      wait_reply();
      chk(ak, eak);
      chk(al, eal);
      chk(replyTag, cmdTag);
      chk(gotFrames, 32'h0);
   endtask
   // pull whose offset plus count passes the transfer length
   task automatic t_over;
      prep(1'b0);
      send(pull(32'd24, 16'h0005), PULL_LEN);
      wait_reply();
      chk(ak, BAD_FIELD_CODE);
      chk(al, 8'h00);
      chk(gotFrames, 32'h0);
   endtask
   task automatic t_grant;
      prep(1'b1);
      send(grant(cmdIssuer, 32'd16, 16'h0009), GRANT_LEN);
      wait_done();
      chk(gotBytes, 32'd16);
      chk(frameRoute, 32'hA5A50F0F);
      chk(framePort, 32'h3);
      chk(frameChannel, 32'h9);
   endtask
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      nrst = 1'b0;
      {rxValid, rxEnd, rxByte, slow, clr} = '0;
      cmdActive = 1'b1;
      cmdTag = 16'h0042;
      cmdIssuer = 32'h00001234;
      cmdLength = 32'd200;
      cmdPort = 8'h01;
      cmdRoute = 32'h00000077;
      repeat (6) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (4) @(negedge clk_sys);
      t_busy();
      cmdLength = 32'd20;
      t_pull();
      t_over();
      cmdLength = 32'd64;
      t_bad(cmdIssuer, 32'd12, BAD_FIELD_CODE, 8'h00);
      t_grant();
      t_bad(32'h00001235, 32'd16, 8'h00, BAD_ISSUER_CODE);
      t_grant();
      cmdActive = 1'b0;
      t_bad(cmdIssuer, 32'd16, 8'h00, UNEXPECTED_CODE);
      cmdActive = 1'b1;
      give_verdict();
   end
endmodule
bind dprm_msg_handler dprm_chk #(.FRAME_BYTES(FRAME_BYTES)) i_chk (
   .clk_sys(clk_sys), .nrst(nrst), .rxEnd(rxEnd), .frameReady(frameReady),
   .frameValid(frameValid), .frameChannel(frameChannel),
   .framePort(framePort), .frameLen(frameLen), .frameLast(frameLast),
   .outstanding(outstanding), .ackValid(ackValid), .alertValid(alertValid));
